/* hw/tecp_timer.sv */
// Local design decisions: the address map and the strobed register port.
`default_nettype none

module tecp_timer (
   input  wire logic                        clk,
   input  wire logic                        rst,
   input  wire logic [tecp_pkg::ADDR_W-1:0] addr,
   input  wire logic [tecp_pkg::DATA_W-1:0] wdata,
   input  wire logic                        wr,
   input  wire logic                        rd,
   output logic      [tecp_pkg::DATA_W-1:0] rdata,
   input  wire logic                        countInputPin,
   input  wire logic                        watchdogTick,
   input  wire logic                        watchdogClearInstruction,
   output logic                             watchdogPostTick,
   output logic                             timerOverflowFlag,
   output logic      [tecp_pkg::DATA_W-1:0] timerCount
);
   import tecp_pkg::*;

   tecp_bus_req_t req;
   tecp_option_t  option;
   logic [1:0]    phase;
   logic [3:0]    inhibitCnt;
   logic          inhibit;
   logic          timerWrite;
   logic          statusWrite;
   logic          srcLevel;
   logic          divSrc;
   logic [2:0]    divTap;
   logic          divBypass;
   logic          divClear;
   logic          divOut;
   logic          timerClkLevel;
   logic          sampFirst;
   logic          sampSecond;
   logic          sampPrev;
   logic          syncEdge;
   logic [INC_PIPE-1:0] incPipe;
   logic          incNow;
   logic          rollover;

   assign req.wr    = wr;
   assign req.rd    = rd;
   assign req.addr  = addr;
   assign req.wdata = wdata;

   assign timerWrite  = req.wr && (req.addr == OFS_TIMER);
   assign statusWrite = req.wr && (req.addr == OFS_STATUS);

   // option register, software-visible configuration
   always_ff @(posedge clk) begin
      if (rst) begin
         option <= tecp_option_t'(OPTION_RST);
      end else if (req.wr && req.addr == OFS_OPTION) begin
         // owner and rate in low four bits
         option <= tecp_option_t'(req.wdata);
      end
   end

   // four-phase oscillator sequencer
   always_ff @(posedge clk) begin
      if (rst) begin
         phase <= 2'h0;
      end else begin
         phase <= phase + 2'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         inhibitCnt <= 4'h0;
      end else if (timerWrite) begin
         inhibitCnt <= 4'(INHIBIT_CLKS);
      end else if (inhibitCnt != 4'h0) begin
         inhibitCnt <= inhibitCnt - 4'h1;
      end
   end

   assign inhibit = (inhibitCnt != 4'h0);

   always_comb begin
      if (option.source) begin
         srcLevel = countInputPin ^ option.edgeFall;
      end else begin
         srcLevel = phase[1];
      end
   end

   always_comb begin
      if (option.owner) begin
         divSrc    = watchdogTick;
         divTap    = option.rate - 3'h1;
         divBypass = (option.rate == 3'h0);
         divClear  = watchdogClearInstruction;
      end else begin
         divSrc    = srcLevel;
         divTap    = option.rate;
         divBypass = 1'b0;
         divClear  = timerWrite || inhibit;
      end
   end

   tecp_ripple_div u_div (
      .clk      (clk),
      .rst      (rst),
      .clear    (divClear),
      .srcLevel (divSrc),
      .tap      (divTap),
      .bypass   (divBypass),
      .divOut   (divOut)
   );

   always_comb begin
      if (option.owner) begin
         timerClkLevel = srcLevel;
      end else begin
         timerClkLevel = divOut;
      end
   end

   // sample on Q2 and Q4
   // reset high: falling-edge select idles high, so no false edge after reset
   always_ff @(posedge clk) begin
      if (rst) begin
         sampFirst <= 1'b1;
      end else if (phase == PH_Q2 || phase == PH_Q4) begin
         sampFirst <= timerClkLevel;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sampSecond <= 1'b1;
         sampPrev   <= 1'b1;
      end else begin
         sampSecond <= sampFirst;
         sampPrev   <= sampSecond;
      end
   end

   assign syncEdge = sampSecond && !sampPrev;

   always_ff @(posedge clk) begin
      if (rst) begin
         incPipe <= '0;
      end else begin
         incPipe <= {incPipe[INC_PIPE-2:0], syncEdge};
      end
   end

   assign incNow   = incPipe[INC_PIPE-1] && !inhibit && !timerWrite;
   assign rollover = incNow && (timerCount == TIMER_MAX);

   // timer count register
   always_ff @(posedge clk) begin
      if (rst) begin
         timerCount <= TIMER_RST;
      end else if (timerWrite) begin
         timerCount <= req.wdata;
      end else if (incNow) begin
         timerCount <= timerCount + 8'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         timerOverflowFlag <= OVF_RST;
      end else if (rollover) begin
         timerOverflowFlag <= 1'b1;
      end else if (statusWrite) begin
         timerOverflowFlag <= req.wdata[OVF_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         watchdogPostTick <= 1'b0;
      end else begin
         watchdogPostTick <= option.owner ? divOut : watchdogTick;
      end
   end

   // read data, one cycle after strobe
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata <= '0;
      end else if (req.rd) begin
         case (req.addr)
            OFS_OPTION: rdata <= option;
            OFS_TIMER:  rdata <= timerCount;
            OFS_STATUS: rdata <= {7'h00, timerOverflowFlag};
            default:    rdata <= '0;
         endcase
      end else begin
         rdata <= '0;
      end
   end

endmodule // tecp_timer

`default_nettype wire

/* hw/tecp_pkg.sv */
// Behaviour
// - undivided external input sampled at Q2, Q4
// - timer prescaler divides input, symmetrical output
// - increment lands 3 to 7 Tosc later
// - one divider, timer or watchdog owner
// - owner and rate from option bits 3:0
// - timer write clears divider when timer-owned
// - watchdog clear clears divider when watchdog-owned
// - divider count has no software access
// - owner may change at any time
// - timer write inhibits counting two cycles
// - edge select zero rising, one falling
// - owner bit one watchdog, zero timer
// - rate codes double timer and watchdog ratio
// - rollover FF to 00 sets overflow flag
`default_nettype none

package tecp_pkg;

   localparam int ADDR_W = 2;
   localparam int DATA_W = 8;

   // register offsets
   localparam logic [ADDR_W-1:0] OFS_OPTION = 2'h0;
   localparam logic [ADDR_W-1:0] OFS_TIMER  = 2'h1;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 2'h2;

   // option field positions
   localparam int RATE_LSB   = 0;
   localparam int RATE_W     = 3;
   localparam int OWNER_BIT  = 3;
   localparam int EDGE_BIT   = 4;
   localparam int SOURCE_BIT = 5;
   // status field positions
   localparam int OVF_BIT    = 0;

   // reset values and timer maximum
   localparam logic [DATA_W-1:0] OPTION_RST = 8'hff;
   localparam logic [DATA_W-1:0] TIMER_RST  = 8'h00;
   localparam logic              OVF_RST    = 1'b0;
   localparam logic [DATA_W-1:0] TIMER_MAX  = 8'hff;

   // timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int TOSC_NS       = 40;
   localparam int TOSC_CLKS     = (TOSC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PHASES        = 4;
   localparam int TCY_CLKS      = PHASES * TOSC_CLKS;
   localparam int INHIBIT_TCY   = 2;
   localparam int INHIBIT_CLKS  = INHIBIT_TCY * TCY_CLKS;
   localparam int INC_MIN_TOSC  = 3;
   localparam int INC_MAX_TOSC  = 7;
   localparam int INC_PIPE      = INC_MIN_TOSC * TOSC_CLKS - 1;

   // phase indices of the four-phase cycle
   localparam logic [1:0] PH_Q2 = 2'h1;
   localparam logic [1:0] PH_Q4 = 2'h3;

   localparam int DIV_W = 8;

   typedef struct packed {
      logic [1:0]        spare;
      logic              source;
      logic              edgeFall;
      logic              owner;
      logic [RATE_W-1:0] rate;
   } tecp_option_t;

   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } tecp_bus_req_t;

endpackage : tecp_pkg

`default_nettype wire

/* hw/tecp_ripple_div.sv */
`default_nettype none

module tecp_ripple_div (
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire logic                   clear,
   input  wire logic                   srcLevel,
   input  wire logic [2:0]             tap,
   input  wire logic                   bypass,
   output logic                        divOut
);
   import tecp_pkg::*;

   logic             prevSrc;
   logic [DIV_W-1:0] count;

   always_ff @(posedge clk) begin
      if (rst) begin
         prevSrc <= 1'b0;
      end else begin
         prevSrc <= srcLevel;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || clear) begin
         count <= '0;
      end else if (srcLevel && !prevSrc) begin
         count <= count + 8'h01;
      end
   end

   assign divOut = bypass ? srcLevel : count[tap];

endmodule // tecp_ripple_div

`default_nettype wire

/* verification/tecp_timer_assertions.sv */
`default_nettype none
module tecp_timer_assertions (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic [1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic [7:0] rdata,
   input wire logic       watchdogTick,
   input wire logic       watchdogPostTick,
   input wire logic       timerOverflowFlag,
   input wire logic [7:0] timerCount
);
   import tecp_pkg::*;
   logic [7:0] opt;
   always_ff @(posedge clk) begin
      if (rst)
         opt <= OPTION_RST;
      else if (wr && addr == OFS_OPTION)
         opt <= wdata;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_idle; !$past(rd) |-> rdata == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("rdata not idle");
   property p_unm; rd && addr == 2'h3 |=> rdata == 8'h00; endproperty
   a_unm: assert property (p_unm) else $error("unmapped read");
   property p_load; wr && addr == OFS_TIMER |=> timerCount == $past(wdata); endproperty
   a_load: assert property (p_load) else $error("timer load");
   property p_inh; wr && addr == OFS_TIMER |=> ##1 $stable(timerCount) [*7]; endproperty
   a_inh: assert property (p_inh) else $error("count during hold");
   property p_step; !$past(wr) && timerCount != $past(timerCount)
      |-> timerCount == $past(timerCount) + 8'h01; endproperty
   a_step: assert property (p_step) else $error("count step");
   property p_ovf; !$past(wr) && $past(timerCount) == TIMER_MAX && timerCount == 8'h00
      |-> ##[0:1] timerOverflowFlag; endproperty
   a_ovf: assert property (p_ovf) else $error("rollover flag");
   property p_keep; timerOverflowFlag && !(wr && addr == OFS_STATUS) |=> timerOverflowFlag; endproperty
   a_keep: assert property (p_keep) else $error("flag lost");
   property p_post; !opt[OWNER_BIT] && !(wr && addr == OFS_OPTION)
      |=> watchdogPostTick == $past(watchdogTick); endproperty
   a_post: assert property (p_post) else $error("watchdog divided");
endmodule // tecp_timer_assertions
bind tecp_timer tecp_timer_assertions u_chk (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .watchdogTick,
   .watchdogPostTick, .timerOverflowFlag, .timerCount);
`default_nettype wire

/* verification/tecp_count_src.sv */
`default_nettype none
module tecp_count_src (
   input  wire logic clk,
   output logic      level
);
   timeunit 1ns;
   timeprecision 1ns;
   initial level = 1'b0;
   task automatic burst(input int n, input int h);
      repeat (n) begin
         repeat (h) @(posedge clk);
         level <= 1'b1;
         repeat (h) @(posedge clk);
         level <= 1'b0;
      end
   endtask
endmodule // tecp_count_src
`default_nettype wire

/* verification/tb_timer_ext_clock_shared_prescaler.sv */
`default_nettype none
module tb_timer_ext_clock_shared_prescaler;
   timeunit 1ns;
   timeprecision 1ns;
   import tecp_pkg::*;
   logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, wdClr = 1'b0;
   logic [1:0] addr = 2'h0;
   logic [7:0] wdata = 8'h00, rdata, cnt, got;
   logic       pin, tick, post, ovf;
   int         mismatches = 0, totalChecks = 0, cyc = 0;
   always #20 clk = ~clk;
   tecp_timer uut (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .countInputPin(pin), .watchdogTick(tick),
      .watchdogClearInstruction(wdClr), .watchdogPostTick(post), .timerOverflowFlag(ovf), .timerCount(cnt));
   tecp_count_src src (.clk, .level(pin));
   tecp_count_src wdg (.clk, .level(tick));
   task automatic conclude;
      $display("checks=%0d mismatches=%0d", totalChecks, mismatches);
      if (mismatches == 0 && totalChecks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      totalChecks++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wreg(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [1:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 got = rdata;
   endtask
   task automatic clr;
      @(posedge clk);
      wdClr <= 1'b1;
      @(posedge clk);
      wdClr <= 1'b0;
   endtask
   task automatic t_div;
      for (int r = 0; r < 8; r++) begin
         clr;
         wreg(OFS_OPTION, 8'h20 | 8'(r));
         wreg(OFS_TIMER, 8'h00);
         repeat (12) @(posedge clk);
         fork
            src.burst(4 << r, 2);
            wdg.burst(8, 3);
         join
         repeat (12) @(posedge clk);
         rreg(OFS_TIMER);
         chk(got, 8'h02);
      end
      $display("t_div done");
   endtask
   task automatic t_lat;
      int n;
      n = 0;
      fork
         src.burst(1, 10);
         begin
            @(posedge pin);
            while (cnt === 8'h05 && n < 20) begin
               @(posedge clk);
               #1 n++;
            end
         end
      join
      chk(8'(n >= 3 && n <= 7), 8'h01);
   endtask
   task automatic t_ext;
      wreg(OFS_OPTION, 8'h21);
      wreg(OFS_TIMER, 8'h00);
      wreg(OFS_OPTION, 8'h29);
      clr;
      for (int e = 0; e < 2; e++) begin
         wreg(OFS_OPTION, e ? 8'h38 : 8'h28);
         wreg(OFS_TIMER, 8'h00);
         repeat (12) @(posedge clk);
         src.burst(5, 2);
         repeat (12) @(posedge clk);
         rreg(OFS_TIMER);
         chk(got, 8'h05);
         if (e == 0)
            t_lat;
      end
      $display("t_ext done");
   endtask
   task automatic t_int;
      wreg(OFS_OPTION, 8'h08);
      wreg(OFS_TIMER, 8'hfd);
      rreg(OFS_TIMER);
      chk(got, 8'hfd);
      for (int i = 0; i < 80 && ovf !== 1'b1; i++)
         @(posedge clk);
      rreg(OFS_STATUS);
      chk(got, 8'h01);
      wreg(OFS_STATUS, 8'h00);
      rreg(OFS_STATUS);
      chk(got, 8'h00);
      rreg(2'h3);
      chk(got, 8'h00);
      $display("t_int done");
   endtask
   task automatic t_wdg;
      int n;
      logic p;
      for (int r = 0; r < 4; r++) begin
         wreg(OFS_OPTION, 8'h08 | 8'(r));
         // stray tick left in the divider, the clear must wipe it
         wdg.burst(1, 3);
         clr;
         n = 0;
         p = 1'b1;
         fork
            wdg.burst(9, 3);
            repeat (70) begin
               @(posedge clk);
               #1;
               if (post && !p)
                  n++;
               p = post;
            end
         join
         chk(8'(n), 8'((9 + (1 << r) / 2) >> r));
      end
      $display("t_wdg done");
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         mismatches++;
         conclude;
      end
   end
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rreg(OFS_OPTION);
      chk(got, OPTION_RST);
      repeat (12) @(posedge clk);
      rreg(OFS_TIMER);
      chk(got, TIMER_RST);
      t_div;
      t_ext;
      t_int;
      t_wdg;
      conclude;
   end
endmodule // tb_timer_ext_clock_shared_prescaler
`default_nettype wire
